// File: pkg/dot_pkg.sv
`default_nettype none
package dot_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    // Mode and latencies in link cycles
    localparam logic [4:0] CWL_RESET   = 5'h05;
    localparam logic [4:0] AL_RESET    = 5'h00;
    localparam logic [4:0] SYNC_OFFSET = 5'h02;
    localparam logic [4:0] ANPD_OFFSET = 5'h01;
    // Asynchronous delays, in ps as printed style, converted to cycles
    localparam int AONPD_MIN_PS = 2000;
    localparam int AONPD_MAX_PS = 8500;
    localparam int AOFPD_MIN_PS = 2000;
    localparam int AOFPD_MAX_PS = 8500;
    localparam logic [4:0] AONPD_MIN_CYC = 5'((AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [4:0] AONPD_MAX_CYC = 5'((AONPD_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : AONPD_MAX_PS / CLK_PERIOD_PS);
    localparam logic [4:0] AOFPD_MIN_CYC = 5'((AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [4:0] AOFPD_MAX_CYC = 5'((AOFPD_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 : AOFPD_MAX_PS / CLK_PERIOD_PS);
    localparam logic [4:0] CPDED_CYC = 5'h01;
    localparam logic [7:0] RFC_CYC   = 8'h0e;
    localparam logic [4:0] XPDLL_CYC = 5'h0a;
    localparam logic [5:0] PIPE_LEN  = 6'h20;
endpackage : dot_pkg
`default_nettype wire

// File: pkg/dot_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dot_link_if;
    logic odt;
    logic cke;
    logic refresh;
    logic rttOn;
    modport ctrl (output odt, output cke, output refresh, input rttOn);
    modport dram (input odt, input cke, input refresh, output rttOn);
endinterface : dot_link_if
`default_nettype wire

// File: rtl/dot_dram_end.sv
`timescale 1ns/100ps
`default_nettype none
module dot_dram_end
    import dot_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    dot_link_if.dram        link,
    input  wire logic       dllFreezeEn,
    input  wire logic [4:0] cwl,
    input  wire logic [4:0] al,
    output logic            asyncMode,
    output logic            inWindow
);
    typedef struct packed {
        logic [1:0]           odtSync;
        logic [1:0]           ckeSync;
        logic [1:0]           refSync;
        logic                 ckePrev;
        logic [PIPE_LEN-1:0]  odtPipe;
        logic                 rtt;
        logic                 async;
        logic                 win;
        logic [7:0]           winCnt;
        logic [7:0]           rfcCnt;
        logic                 asyncOdt;
        logic [4:0]           asyncCnt;
    } dot_dram_st_t;

    dot_dram_st_t s_reg, s_next;
    logic [4:0] syncLat;
    logic       odtIn, ckeIn;

    assign odtIn = s_reg.odtSync[1];
    assign ckeIn = s_reg.ckeSync[1];

    always_comb
    begin
        s_next = s_reg;
        syncLat = 5'(cwl + al - SYNC_OFFSET);
        s_next.odtSync = {s_reg.odtSync[0], link.odt};
        s_next.ckeSync = {s_reg.ckeSync[0], link.cke};
        s_next.refSync = {s_reg.refSync[0], link.refresh};
        s_next.ckePrev = ckeIn;
        s_next.odtPipe = {s_reg.odtPipe[PIPE_LEN-2:0], odtIn};
        if (s_reg.rfcCnt != 8'h00)
            s_next.rfcCnt = s_reg.rfcCnt - 8'h01;
        if (s_reg.refSync[1])
            s_next.rfcCnt = RFC_CYC;
        // Asynchronous only once powered down with frozen DLL
        s_next.async = dllFreezeEn && !ckeIn;
        // Window: entry stretch of tCPDED or running refresh, exit of tXPDLL
        if (s_reg.winCnt != 8'h00)
            s_next.winCnt = s_reg.winCnt - 8'h01;
        if (dllFreezeEn && s_reg.ckePrev && !ckeIn)
            s_next.winCnt = (s_reg.rfcCnt > 8'(CPDED_CYC)) ? s_reg.rfcCnt : 8'(CPDED_CYC);
        if (dllFreezeEn && !s_reg.ckePrev && ckeIn)
            s_next.winCnt = (s_reg.winCnt > 8'(XPDLL_CYC)) ? s_reg.winCnt : 8'(XPDLL_CYC);
        s_next.win = s_next.winCnt != 8'h00;
        // Asynchronous path: raw ODT with fixed delay, no AL
        if (odtIn != s_reg.asyncOdt)
        begin
            s_next.asyncCnt = s_reg.asyncCnt + 5'h01;
            if (s_reg.asyncCnt + 5'h01 >= (odtIn ? AONPD_MIN_CYC : AOFPD_MIN_CYC))
            begin
                s_next.asyncOdt = odtIn;
                s_next.asyncCnt = 5'h00;
            end
        end
        else
            s_next.asyncCnt = 5'h00;
        // Window allows either; we pick asynchronous which meets bounds
        if (s_reg.async || s_reg.win)
            s_next.rtt = s_reg.asyncOdt;
        else
            s_next.rtt = (syncLat == 5'h00) ? odtIn : s_reg.odtPipe[syncLat - 5'h01];
        if (!resetn)
        begin
            s_next = '0;
        end
    end

    always_ff @(posedge clk_sys)
        s_reg <= s_next;

    always_comb
    begin
        link.rttOn = s_reg.rtt;
        asyncMode  = s_reg.async;
        inWindow   = s_reg.win;
    end
endmodule : dot_dram_end
`default_nettype wire

// File: rtl/dot_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
module dot_ctrl_end
    import dot_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    dot_link_if.ctrl        link,
    input  wire logic       odtReq,
    input  wire logic       pdReq,
    input  wire logic       refReq,
    input  wire logic [4:0] cwl,
    input  wire logic [4:0] al,
    output logic            odtHeld,
    output logic            rttUncertain
);
    typedef struct packed {
        logic       odt;
        logic       cke;
        logic       ref_;
        logic [4:0] leadCnt;
        logic [7:0] guardCnt;
        logic       held;
        logic       unc;
    } dot_ctrl_st_t;

    dot_ctrl_st_t s_reg, s_next;
    logic [4:0] anpd;

    always_comb
    begin
        s_next = s_reg;
        anpd = 5'(cwl + al - ANPD_OFFSET);
        s_next.ref_ = refReq && s_reg.cke;
        // Freeze ODT for tANPD before a CKE change and through the guard
        if (pdReq != !s_reg.cke)
        begin
            if (s_reg.leadCnt >= anpd)
            begin
                s_next.cke = !pdReq;
                s_next.leadCnt = 5'h00;
                s_next.guardCnt = 8'(XPDLL_CYC) + RFC_CYC + 8'(PIPE_LEN);
            end
            else
                s_next.leadCnt = s_reg.leadCnt + 5'h01;
        end
        else
            s_next.leadCnt = 5'h00;
        if (s_reg.guardCnt != 8'h00)
            s_next.guardCnt = s_reg.guardCnt - 8'h01;
        s_next.unc = (s_next.leadCnt != 5'h00) || (s_next.guardCnt != 8'h00);
        s_next.held = s_next.unc && (odtReq != s_reg.odt);
        if (!s_next.unc)
            s_next.odt = odtReq;
        if (!resetn)
        begin
            s_next = '0;
            s_next.cke = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
        s_reg <= s_next;

    always_comb
    begin
        link.odt     = s_reg.odt;
        link.cke     = s_reg.cke;
        link.refresh = s_reg.ref_;
        odtHeld      = s_reg.held;
        rttUncertain = s_reg.unc;
    end
endmodule : dot_ctrl_end
`default_nettype wire

// File: dv/dot_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dot_link_asserts
    import dot_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       odt,
    input wire logic       cke,
    input wire logic       rttOn,
    input wire logic       asyncMode,
    input wire logic       inWindow,
    input wire logic       rttUncertain,
    input wire logic       dllFreezeEn,
    input wire logic [4:0] cwl,
    input wire logic [4:0] al
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic       calm;
    logic [4:0] ageReg;
    assign calm = !asyncMode && !inWindow;
    // Saturates so a long idle never wraps
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || $changed(odt))
            ageReg <= 5'h00;
        else if (ageReg != 5'h1f)
            ageReg <= ageReg + 5'h01;
    end
    AST_SYNC_ON: assert property ($rose(rttOn) && calm |-> ageReg == 5'(cwl + al))
        else $error("sync on late");
    AST_SYNC_OFF: assert property ($fell(rttOn) && calm |-> ageReg == 5'(cwl + al))
        else $error("sync off late");
    AST_ASYNC_ON: assert property ($rose(rttOn) && asyncMode |-> ageReg == AONPD_MIN_CYC + 5'h02)
        else $error("async on late");
    AST_ASYNC_OFF: assert property ($fell(rttOn) && asyncMode |-> ageReg == AOFPD_MIN_CYC + 5'h02)
        else $error("async off late");
    AST_NO_FREEZE: assert property (!dllFreezeEn [*3] |-> !asyncMode)
        else $error("async unfrozen");
    AST_HOLD: assert property (rttUncertain && $past(rttUncertain) |-> $stable(odt))
        else $error("odt moved");
    AST_ENTRY_WIN: assert property ($fell(cke) && dllFreezeEn |-> ##[0:4] inWindow)
        else $error("no entry window");
    AST_EXIT_WIN: assert property ($rose(cke) && dllFreezeEn |-> ##4 inWindow [*6])
        else $error("exit window short");
    cover property ($rose(asyncMode));
    cover property ($rose(inWindow));
    cover property ($rose(rttUncertain));
endmodule : dot_link_asserts
`default_nettype wire

// File: dv/ddr3_odt_powerdown_mode_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddr3_odt_powerdown_mode_timing_tb;
    import dot_pkg::*;
    logic       clk_sys, resetn, dllFreezeEn, odtReq, pdReq, refReq, asyncMode, inWindow, odtHeld, rttUncertain;
    logic [4:0] cwl, al;
    int         miscompares, cmp_count, n;
    // Freeze, power-down, odt, then expected rtt and async
    logic [4:0] rows [7] = '{5'h06, 5'h0e, 5'h00, 5'h19, 5'h1f, 5'h16, 5'h10};
    dot_link_if  dot_link_if_i ();
    dot_ctrl_end dot_ctrl_end_i (.clk_sys, .resetn, .link(dot_link_if_i.ctrl), .odtReq, .pdReq, .refReq, .cwl, .al,
        .odtHeld, .rttUncertain);
    dot_dram_end dot_dram_end_i (.clk_sys, .resetn, .link(dot_link_if_i.dram), .dllFreezeEn, .cwl, .al, .asyncMode,
        .inWindow);
    dot_link_asserts dot_link_asserts_i (.clk_sys, .resetn, .odt(dot_link_if_i.odt), .cke(dot_link_if_i.cke),
        .rttOn(dot_link_if_i.rttOn), .asyncMode, .inWindow, .rttUncertain, .dllFreezeEn, .cwl, .al);
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %h, expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic lat(input logic [4:0] w, input logic [4:0] a, input logic [7:0] exp);
        odtReq = 1'b0;
        step(30);
        {cwl, al} = {w, a};
        step(4);
        odtReq = 1'b1;
        for (n = 0; n < 40 && dot_link_if_i.odt !== 1'b1; n++)
            step(1);
        for (n = 0; n < 40 && dot_link_if_i.rttOn !== 1'b1; n++)
            step(1);
        cmp(8'(n), exp);
        $display("latency test done");
        if (n == 40)
            complete_run();
    endtask : lat
    initial
    begin
        {resetn, dllFreezeEn, odtReq, pdReq, refReq, cwl, al} = {5'h00, CWL_RESET, AL_RESET};
        step(2);
        resetn = 1'b1;
        cmp(8'({dot_link_if_i.cke, dot_link_if_i.rttOn, odtHeld, asyncMode, inWindow, rttUncertain}), 8'h20);
        foreach (rows[i])
        begin
            {dllFreezeEn, pdReq, odtReq} = rows[i][4:2];
            // Covers the lead, the 56-cycle guard and the latency
            step(90);
            cmp(8'({dot_link_if_i.cke, dot_link_if_i.rttOn, asyncMode}), 8'({~rows[i][3], rows[i][1:0]}));
        end
        $display("row test done");
        lat(CWL_RESET, AL_RESET, 8'(CWL_RESET + AL_RESET + 5'h01));
        lat(5'h06, 5'h02, 8'h09);
        // Settle in powerdown with odt low before timing the async path
        {dllFreezeEn, pdReq, odtReq} = 3'b110;
        step(90);
        lat(5'h06, 5'h02, 8'(AONPD_MIN_CYC + 5'h03));
        {pdReq, odtReq} = 2'b00;
        step(40);
        refReq = 1'b1;
        step(1);
        {pdReq, refReq} = 2'b10;
        step(2);
        // Odt is frozen high here, so a low request must be held off
        odtReq = 1'b0;
        for (n = 0; n < 40 && odtHeld !== 1'b1; n++)
            step(1);
        cmp(8'(odtHeld), 8'h01);
        $display("hold test done");
        if (n == 40)
            complete_run();
        resetn = 1'b0;
        step(2);
        cmp(8'({dot_link_if_i.cke, dot_link_if_i.rttOn, odtHeld, asyncMode, inWindow, rttUncertain}), 8'h20);
        $display("reset test done");
        complete_run();
    end
endmodule : ddr3_odt_powerdown_mode_timing_tb
`default_nettype wire
